// [logic/probe_lamp_pkg.sv]
`default_nettype none

package probe_lamp_pkg;

    // lamp colour codes driven to the front-panel lamp drivers
    typedef enum logic [2:0] {
        COL_OFF    = 3'h0,
        COL_RED    = 3'h1,
        COL_GREEN  = 3'h2,
        COL_BLUE   = 3'h3,
        COL_YELLOW = 3'h4,
        COL_WHITE  = 3'h5,
        COL_PURPLE = 3'h6,
        COL_LBLUE  = 3'h7
    } colour_t;

    // debug-mode connection states
    typedef enum logic [1:0] {
        DBG_CONN   = 2'b01,
        DBG_LINKED = 2'b10
    } dbg_state_t;

    // flash sequencer states
    typedef enum logic [5:0] {
        FL_SEL  = 6'b000001,
        FL_CONN = 6'b000010,
        FL_RUN  = 6'b000100,
        FL_WAIT = 6'b001000,
        FL_OK   = 6'b010000,
        FL_ERR  = 6'b100000
    } flash_state_t;

    // flash operation codes
    localparam logic [1:0] OP_ERASE  = 2'h0;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_VERIFY = 2'h2;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MASK   = 12'h008;
    localparam logic [11:0] OFS_STATE  = 12'h00C;

    // control fields and reset value
    localparam int          CTRL_LAMP_EN_BIT = 0;
    localparam int          CTRL_RESTART_BIT = 1;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
    localparam logic [31:0] MASK_RESET       = 32'h0000_0000;

    // event bits of status and mask
    localparam int EV_LINK_UP   = 0;
    localparam int EV_TGT_LOST  = 1;
    localparam int EV_FLASH_OK  = 2;
    localparam int EV_FLASH_ERR = 3;
    localparam int EV_TRC_FULL  = 4;
    localparam int EV_WIDTH     = 5;

    // blink timing
    localparam int BLINK_HALF_MS      = 250;
    localparam int CLK_PERIOD_NS      = 100;
    localparam int BLINK_HALF_CYCLES  = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// [logic/probe_lamp_ctrl.sv]
// Functional notes
// - core lamp green for first core family, blue for second family
// - debug mode: link lamp steady red while no target present
// - debug mode: link lamp blinks red when target present but link fails
// - debug mode: link lamp steady blue once target connection succeeded
// - debug mode initial connection: link lamp yellow during host enumeration
// - debug mode: run lamp steady red while target runs user program
// - after connection, power loss or removal lights run red until restored and restart
// - run lamp green while target halted, off otherwise
// - trace lamp off when disabled, light blue enabled, yellow when memory full
// - erase lamp white selected, blinking busy, green ok, red failure
// - write lamp purple selected, blinking busy, green ok, red failure
// - verify lamp yellow selected, blinking busy, green pass, red fail
// - flash initial connection: erase lamp red no target, blinking red link fails
// - mode switches: open/open debug, a erase-write, b verify, both all three
// - flash restart launches sequence; with result showing, first return to selected
// - switches sampled only on the first clock after reset and at restart (button press or CTRL restart bit)
`timescale 1ns/1ps
`default_nettype none

module probe_lamp_ctrl
    import probe_lamp_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // front-panel switches and button
    input  wire logic        core_family_select_switch,
    input  wire logic        mode_select_switch_a,
    input  wire logic        mode_select_switch_b,
    input  wire logic        restart_button,
    // debug-link status
    input  wire logic        usb_enumerating,
    input  wire logic        target_present,
    input  wire logic        target_power_ok,
    input  wire logic        link_established,
    input  wire logic        target_run_state,
    input  wire logic        trace_capture,
    input  wire logic        trace_memory_full,
    // flash sequencing handshake
    output logic             flash_op_start,
    output logic      [1:0]  flash_op_code,
    input  wire logic        flash_op_done,
    input  wire logic        flash_op_failed,
    // lamps and interrupt
    output logic      [2:0]  core_family_lamp,
    output logic      [2:0]  link_or_erase_lamp,
    output logic      [2:0]  run_or_write_verify_lamp,
    output logic      [2:0]  trace_state_lamp,
    output logic             irq
);

    if (BLINK_HALF < 2) begin : g_bad_blink
        $error("BLINK_HALF must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb register file

    logic [31:0]         ctrl_q;
    logic [EV_WIDTH-1:0] status_q;
    logic [EV_WIDTH-1:0] mask_q;
    logic [EV_WIDTH-1:0] event_d;
    logic                wr_en;
    logic                mapped;
    logic [31:0]         rdata_d;
    logic [31:0]         state_word;

    assign wr_en  = psel && penable && pready && pwrite;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                    (paddr == OFS_MASK) || (paddr == OFS_STATE);

    always_comb begin
        unique case (paddr)
            OFS_CTRL:   rdata_d = ctrl_q;
            OFS_STATUS: rdata_d = {{(32-EV_WIDTH){1'b0}}, status_q};
            OFS_MASK:   rdata_d = {{(32-EV_WIDTH){1'b0}}, mask_q};
            OFS_STATE:  rdata_d = state_word;
            default:    rdata_d = 32'h0000_0000;
        endcase
    end

    // zero wait states: ready during the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // restart bit self-clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && paddr == OFS_CTRL) begin
            ctrl_q <= {30'h0000_0000, pwdata[CTRL_RESTART_BIT], pwdata[CTRL_LAMP_EN_BIT]};
        end else begin
            ctrl_q[CTRL_RESTART_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MASK_RESET[EV_WIDTH-1:0];
        end else if (wr_en && paddr == OFS_MASK) begin
            mask_q <= pwdata[EV_WIDTH-1:0];
        end
    end

    // write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else if (wr_en && paddr == OFS_STATUS) begin
            status_q <= (status_q & ~pwdata[EV_WIDTH-1:0]) | event_d;
        end else begin
            status_q <= status_q | event_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // restart, switch sampling and blink timebase

    logic        btn_q;
    logic        booted_q;
    logic        restart_evt;
    logic        core_q;
    logic [2:0]  plan_q;
    logic        debug_mode;
    logic [31:0] blink_cnt_q;
    logic        blink_q;

    assign restart_evt = (restart_button && !btn_q) || ctrl_q[CTRL_RESTART_BIT];
    assign debug_mode  = (plan_q == 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_q    <= 1'b0;
            booted_q <= 1'b0;
            core_q   <= 1'b0;
            plan_q   <= 3'h0;
        end else begin
            btn_q    <= restart_button;
            booted_q <= 1'b1;
            if (restart_evt || !booted_q) begin
                core_q <= core_family_select_switch;
                // plan bits: verify, write, erase
                plan_q <= {mode_select_switch_b, mode_select_switch_a, mode_select_switch_a};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK_HALF - 1)) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // debug-mode connection tracking

    dbg_state_t dbg_q;
    logic       lost_q;
    logic       trc_full_q;
    logic       tgt_ok;

    assign tgt_ok = target_present && target_power_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_q  <= DBG_CONN;
            lost_q <= 1'b0;
        end else begin
            if (restart_evt) begin
                dbg_q <= DBG_CONN;
            end else if (dbg_q == DBG_CONN && link_established && tgt_ok && !usb_enumerating) begin
                dbg_q <= DBG_LINKED;
            end
            if (dbg_q == DBG_LINKED && !tgt_ok) begin
                lost_q <= 1'b1;
            end else if (restart_evt && tgt_ok) begin
                lost_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trc_full_q <= 1'b0;
        end else begin
            trc_full_q <= trace_memory_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash operation sequencer

    flash_state_t fl_q;
    logic [1:0]   op_q;
    logic [2:0]   ok_q;
    logic [1:0]   next_op;
    logic         has_next;

    always_comb begin
        has_next = 1'b0;
        next_op  = OP_VERIFY;
        if (op_q == OP_ERASE && plan_q[1]) begin
            has_next = 1'b1;
            next_op  = OP_WRITE;
        end else if (op_q != OP_VERIFY && plan_q[2]) begin
            has_next = 1'b1;
            next_op  = OP_VERIFY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_q           <= FL_SEL;
            op_q           <= OP_ERASE;
            ok_q           <= 3'h0;
            flash_op_start <= 1'b0;
            flash_op_code  <= OP_ERASE;
        end else begin
            flash_op_start <= 1'b0;
            if (restart_evt) begin
                ok_q <= 3'h0;
                op_q <= OP_ERASE;
                // a result showing returns to selected first
                fl_q <= (fl_q == FL_SEL && !debug_mode) ? FL_CONN : FL_SEL;
            end else begin
                unique case (fl_q)
                    FL_SEL: ;
                    FL_CONN: begin
                        if (link_established && tgt_ok) begin
                            fl_q <= FL_RUN;
                            op_q <= plan_q[0] ? OP_ERASE : OP_VERIFY;
                        end
                    end
                    FL_RUN: begin
                        flash_op_start <= 1'b1;
                        flash_op_code  <= op_q;
                        fl_q           <= FL_WAIT;
                    end
                    FL_WAIT: begin
                        if (flash_op_done) begin
                            if (flash_op_failed) begin
                                fl_q <= FL_ERR;
                            end else begin
                                ok_q[op_q] <= 1'b1;
                                if (has_next) begin
                                    op_q <= next_op;
                                    fl_q <= FL_RUN;
                                end else begin
                                    fl_q <= FL_OK;
                                end
                            end
                        end
                    end
                    FL_OK: ;
                    FL_ERR: ;
                endcase
            end
        end
    end

    always_comb begin
        event_d               = '0;
        event_d[EV_LINK_UP]   = dbg_q == DBG_CONN && !restart_evt && link_established &&
                                tgt_ok && !usb_enumerating;
        event_d[EV_TGT_LOST]  = dbg_q == DBG_LINKED && !tgt_ok && !lost_q;
        event_d[EV_FLASH_OK]  = fl_q == FL_WAIT && flash_op_done && !flash_op_failed &&
                                !has_next && !restart_evt;
        event_d[EV_FLASH_ERR] = fl_q == FL_WAIT && flash_op_done && flash_op_failed &&
                                !restart_evt;
        event_d[EV_TRC_FULL]  = trace_memory_full && !trc_full_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // lamp colour selection

    colour_t core_d;
    colour_t lamp2_d;
    colour_t lamp3_d;
    colour_t lamp4_d;
    logic    l3_verify;
    logic    l3_sel;
    logic    blink_on;

    assign blink_on  = blink_q;
    // lamp 3 follows verify when write is not planned, else write until the verify step is reached
    assign l3_verify = !plan_q[1] || (plan_q[2] && op_q == OP_VERIFY && fl_q != FL_SEL);
    assign l3_sel    = l3_verify ? plan_q[2] : plan_q[1];

    always_comb begin
        core_d  = core_q ? COL_BLUE : COL_GREEN;
        lamp2_d = COL_OFF;
        lamp3_d = COL_OFF;
        lamp4_d = COL_OFF;
        if (debug_mode) begin
            if (dbg_q == DBG_LINKED) begin
                lamp2_d = COL_BLUE;
            end else if (usb_enumerating) begin
                lamp2_d = COL_YELLOW;
            end else if (!target_present) begin
                lamp2_d = COL_RED;
            end else begin
                lamp2_d = blink_on ? COL_RED : COL_OFF;
            end
            if (dbg_q == DBG_LINKED) begin
                if (lost_q || target_run_state) begin
                    lamp3_d = COL_RED;
                end else begin
                    lamp3_d = COL_GREEN;
                end
            end
            if (trace_capture) begin
                lamp4_d = trace_memory_full ? COL_YELLOW : COL_LBLUE;
            end
        end else begin
            if (fl_q == FL_CONN) begin
                lamp2_d = (!target_present || blink_on) ? COL_RED : COL_OFF;
            end else if (plan_q[0]) begin
                if (fl_q == FL_ERR && op_q == OP_ERASE) begin
                    lamp2_d = COL_RED;
                end else if (ok_q[OP_ERASE]) begin
                    lamp2_d = COL_GREEN;
                end else if (fl_q != FL_SEL && op_q == OP_ERASE && !blink_on) begin
                    lamp2_d = COL_OFF;
                end else begin
                    lamp2_d = COL_WHITE;
                end
            end
            if (l3_sel && fl_q != FL_CONN) begin
                if (fl_q == FL_ERR && op_q == (l3_verify ? OP_VERIFY : OP_WRITE)) begin
                    lamp3_d = COL_RED;
                end else if (ok_q[l3_verify ? OP_VERIFY : OP_WRITE]) begin
                    lamp3_d = COL_GREEN;
                end else if ((fl_q == FL_RUN || fl_q == FL_WAIT) &&
                             op_q == (l3_verify ? OP_VERIFY : OP_WRITE) && !blink_on) begin
                    lamp3_d = COL_OFF;
                end else begin
                    lamp3_d = l3_verify ? COL_YELLOW : COL_PURPLE;
                end
            end
        end
        if (!ctrl_q[CTRL_LAMP_EN_BIT]) begin
            core_d  = COL_OFF;
            lamp2_d = COL_OFF;
            lamp3_d = COL_OFF;
            lamp4_d = COL_OFF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_family_lamp         <= COL_OFF;
            link_or_erase_lamp       <= COL_OFF;
            run_or_write_verify_lamp <= COL_OFF;
            trace_state_lamp         <= COL_OFF;
        end else begin
            core_family_lamp         <= core_d;
            link_or_erase_lamp       <= lamp2_d;
            run_or_write_verify_lamp <= lamp3_d;
            trace_state_lamp         <= lamp4_d;
        end
    end

    assign state_word = {16'h0000, fl_q, dbg_q, lost_q, core_q, blink_q, plan_q, op_q};

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic lamps_on;
    assign lamps_on = ctrl_q[CTRL_LAMP_EN_BIT];

    a_core_colour: assert property (lamps_on |=> core_family_lamp ==
        ($past(core_q) ? COL_BLUE : COL_GREEN)) else $error("core lamp colour wrong");
    a_link_red: assert property (lamps_on && debug_mode && dbg_q == DBG_CONN &&
        !usb_enumerating && !target_present |=> link_or_erase_lamp == COL_RED)
        else $error("link lamp not red without target");
    a_link_blink: assert property (lamps_on && debug_mode && dbg_q == DBG_CONN &&
        !usb_enumerating && target_present && !blink_q |=> link_or_erase_lamp == COL_OFF)
        else $error("link lamp not blinking");
    a_link_blue: assert property (lamps_on && debug_mode && dbg_q == DBG_LINKED
        |=> link_or_erase_lamp == COL_BLUE) else $error("link lamp not blue");
    a_usb_yellow: assert property (lamps_on && debug_mode && dbg_q == DBG_CONN &&
        usb_enumerating |=> link_or_erase_lamp == COL_YELLOW) else $error("no yellow");
    a_run_red: assert property (lamps_on && debug_mode && dbg_q == DBG_LINKED &&
        target_run_state |=> run_or_write_verify_lamp == COL_RED) else $error("run not red");
    a_lost_hold: assert property (lost_q && !(restart_evt && tgt_ok) |=> lost_q)
        else $error("lost flag dropped early");
    a_trace_full: assert property (lamps_on && debug_mode && trace_capture &&
        trace_memory_full |=> trace_state_lamp == COL_YELLOW) else $error("trace not yellow");
    a_op_start: assert property ($rose(flash_op_start) |-> $past(fl_q) == FL_RUN &&
        fl_q == FL_WAIT) else $error("flash start outside run");
    a_blink_half: assert property ($changed(blink_q) |->
        $past(blink_cnt_q) == 32'(BLINK_HALF - 1)) else $error("blink period wrong");

    c_linked: cover property (dbg_q == DBG_CONN ##1 dbg_q == DBG_LINKED);
    c_flash_ok: cover property (fl_q == FL_WAIT ##1 fl_q == FL_OK);
    c_flash_err: cover property (fl_q == FL_WAIT ##1 fl_q == FL_ERR);
    c_lost: cover property ($rose(lost_q));

endmodule

`default_nettype wire

// [verif/flash_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none

module flash_seq_model
    import probe_lamp_pkg::*;
#(
    parameter int DELAY = 40
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // handshake from the lamp controller
    input  wire logic       flash_op_start,
    input  wire logic [1:0] flash_op_code,
    // operation that is to fail, 3 for none
    input  wire logic [1:0] fail_op,
    // answer
    output logic            flash_op_done,
    output logic            flash_op_failed
);
    int         cnt;
    logic [1:0] code_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt             <= 0;
            code_q          <= 2'h0;
            flash_op_done   <= 1'b0;
            flash_op_failed <= 1'b0;
        end else begin
            flash_op_done   <= 1'b0;
            // failure flag is meaningless outside done, so keep it moving
            flash_op_failed <= ~flash_op_failed;
            if (flash_op_start) begin
                cnt    <= DELAY;
                code_q <= flash_op_code;
            end else if (cnt == 1) begin
                cnt             <= 0;
                flash_op_done   <= 1'b1;
                flash_op_failed <= (code_q == fail_op);
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    import probe_lamp_pkg::*;
    localparam int HALF = 4;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic er;
    logic core_family_select_switch = 1'b0, mode_select_switch_a = 1'b0;
    logic mode_select_switch_b = 1'b0, restart_button = 1'b0, usb_enumerating = 1'b0;
    logic target_present = 1'b0, target_power_ok = 1'b0, link_established = 1'b0;
    logic target_run_state = 1'b0, trace_capture = 1'b0, trace_memory_full = 1'b0;
    logic flash_op_start, flash_op_done, flash_op_failed;
    logic [1:0] flash_op_code, fail_op = 2'h3;
    logic [2:0] core_family_lamp, link_or_erase_lamp, run_or_write_verify_lamp;
    logic [2:0] trace_state_lamp;
    logic [1:0] ops[$];
    logic [1:0] tin[3] = '{2'b00, 2'b10, 2'b11};
    logic [2:0] tcol[3] = '{COL_OFF, COL_LBLUE, COL_YELLOW};
    int n_mismatch = 0, tests_run = 0, cyc = 0;

    probe_lamp_ctrl #(.BLINK_HALF(HALF)) u_probe_lamp_ctrl (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .core_family_select_switch, .mode_select_switch_a, .mode_select_switch_b,
        .restart_button, .usb_enumerating, .target_present, .target_power_ok,
        .link_established, .target_run_state, .trace_capture, .trace_memory_full,
        .flash_op_start, .flash_op_code, .flash_op_done, .flash_op_failed,
        .core_family_lamp, .link_or_erase_lamp, .run_or_write_verify_lamp,
        .trace_state_lamp, .irq);
    flash_seq_model u_flash_seq_model (.pclk, .presetn, .flash_op_start, .flash_op_code,
        .fail_op, .flash_op_done, .flash_op_failed);

    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        if (flash_op_start === 1'b1) ops.push_back(flash_op_code);
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one idle edge after each transfer keeps back-to-back calls single-driven
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic press();
        restart_button <= 1'b1;
        tick(3);
        restart_button <= 1'b0;
        tick(3);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        tick(3);
        presetn <= 1'b1;
        tick(3);
    endtask
    // counts lit and dark cycles of a blinking lamp over two full periods
    task automatic blink_seen(ref logic [2:0] l, input logic [2:0] c);
        int on, off;
        on = 0;
        off = 0;
        repeat (4 * HALF) begin
            @(posedge pclk);
            if (l === c) on++;
            if (l === COL_OFF) off++;
        end
        chk({on[15:0], off[15:0]}, {16'(2 * HALF), 16'(2 * HALF)});
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        apb(1'b0, OFS_MASK, 32'h0);
        chk(rd, MASK_RESET);
        apb(1'b0, 12'h010, 32'h0);
        chk({er, rd}, 33'h1_0000_0000);
        chk(core_family_lamp, COL_GREEN);
        usb_enumerating <= 1'b1;
        tick(3);
        chk(link_or_erase_lamp, COL_YELLOW);
        chk(run_or_write_verify_lamp, COL_OFF);
        usb_enumerating <= 1'b0;
        tick(3);
        chk(link_or_erase_lamp, COL_RED);
        target_present <= 1'b1;
        target_power_ok <= 1'b1;
        tick(3);
        blink_seen(link_or_erase_lamp, COL_RED);
        link_established <= 1'b1;
        tick(3);
        chk(link_or_erase_lamp, COL_BLUE);
        chk(run_or_write_verify_lamp, COL_GREEN);
        target_run_state <= 1'b1;
        tick(3);
        chk(run_or_write_verify_lamp, COL_RED);
        target_run_state <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            {trace_capture, trace_memory_full} <= tin[i];
            tick(3);
            chk(trace_state_lamp, tcol[i]);
        end
        core_family_select_switch <= 1'b1;
        apb(1'b1, OFS_MASK, 32'(1 << EV_TGT_LOST));
        target_power_ok <= 1'b0;
        tick(3);
        chk(core_family_lamp, COL_GREEN);
        chk({irq, run_or_write_verify_lamp}, {1'b1, COL_RED});
        target_power_ok <= 1'b1;
        tick(3);
        chk(run_or_write_verify_lamp, COL_RED);
        apb(1'b1, OFS_STATUS, 32'(1 << EV_TGT_LOST));
        tick(3);
        chk(irq, 1'b0);
        press();
        tick(10);
        chk(run_or_write_verify_lamp, COL_GREEN);
        chk(core_family_lamp, COL_BLUE);
        $display("test debug done");

        core_family_select_switch <= 1'b0;
        mode_select_switch_a <= 1'b1;
        target_present <= 1'b0;
        link_established <= 1'b0;
        do_reset();
        chk(link_or_erase_lamp, COL_WHITE);
        chk(run_or_write_verify_lamp, COL_PURPLE);
        press();
        chk(link_or_erase_lamp, COL_RED);
        target_present <= 1'b1;
        tick(3);
        blink_seen(link_or_erase_lamp, COL_RED);
        link_established <= 1'b1;
        tick(3);
        blink_seen(link_or_erase_lamp, COL_WHITE);
        tick(40);
        chk(link_or_erase_lamp, COL_GREEN);
        blink_seen(run_or_write_verify_lamp, COL_PURPLE);
        tick(60);
        chk(run_or_write_verify_lamp, COL_GREEN);
        chk({ops.size(), ops[0], ops[1]}, {32'd2, OP_ERASE, OP_WRITE});
        press();
        chk(link_or_erase_lamp, COL_WHITE);
        mode_select_switch_a <= 1'b0;
        mode_select_switch_b <= 1'b1;
        fail_op <= OP_VERIFY;
        press();
        tick(60);
        chk(run_or_write_verify_lamp, COL_RED);
        chk({ops.size(), ops[2]}, {32'd3, OP_VERIFY});
        press();
        chk(run_or_write_verify_lamp, COL_YELLOW);
        mode_select_switch_a <= 1'b1;
        fail_op <= 2'h3;
        press();
        tick(200);
        chk(run_or_write_verify_lamp, COL_GREEN);
        chk({ops.size(), ops[3], ops[4], ops[5]},
            {32'd6, OP_ERASE, OP_WRITE, OP_VERIFY});
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        tick(2);
        chk({core_family_lamp, run_or_write_verify_lamp}, {COL_OFF, COL_OFF});
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        tick(2);
        chk(link_or_erase_lamp, COL_WHITE);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        $display("test flash done");
        print_verdict();
    end
endmodule

`default_nettype wire
